/* File: include/hcsmr_pkg.sv */
package hcsmr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_BUS_ERR = 8'h06;
  localparam logic [7:0] OFF_STRAP_CFG = 8'h08;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h10;
  localparam logic [7:0] OFF_ADDR_MID = 8'h12;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h14;
  localparam logic [7:0] OFF_CLK_CTRL = 8'h20;

  // Bus error status fields
  localparam int BAD_FLAG_BIT = 15;
  localparam int BAD_VAL_LSB = 11;

  // Strap configuration fields
  localparam int CFG_ENDIAN_BIT = 10;
  localparam int CFG_NVM_BIT = 9;
  localparam int CFG_BUS8_BIT = 7;
  localparam int CFG_BUS16_BIT = 6;
  localparam int CFG_BUS32_BIT = 5;
  localparam int CFG_PKG_BIT = 3;

  // Clock control fields
  localparam int CLK_DRIVE_BIT = 6;
  localparam int CLK_SEL_BIT = 2;
  localparam logic [15:0] CLK_CTRL_WMASK = 16'h0047;
  localparam logic [15:0] CLK_CTRL_RESET = 16'h0000;
  localparam logic [1:0] DIV_BY1 = 2'h0;
  localparam logic [1:0] DIV_BY2 = 2'h1;
  localparam logic [1:0] DIV_BY3 = 2'h2;

  // Nonvolatile memory word addresses of the station address
  localparam logic [7:0] NVM_WORD_LOW = 8'h01;
  localparam logic [7:0] NVM_WORD_MID = 8'h02;
  localparam logic [7:0] NVM_WORD_HIGH = 8'h03;

  // Timing
  localparam int BUS_CLK_MHZ = 125;
  localparam int SYS_CLK_MHZ = 100;

  typedef enum logic [1:0] {
    LD_IDLE,
    LD_REQ,
    LD_WAIT,
    LD_DONE
  } hcsmr_load_t;

  typedef struct packed {
    logic strb;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be_n;
    logic [15:0] wdata;
  } hcsmr_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic rvalid;
  } hcsmr_rsp_t;

  typedef struct packed {
    hcsmr_load_t ld;
    logic [1:0] word_idx;
    logic [2:0] pin_sync1;
    logic [2:0] pin_sync2;
    logic [1:0] sync_cnt;
    logic strap_taken;
    logic bad_flag;
    logic [3:0] bad_val;
    logic endian;
    logic nvm_en;
    logic bus8;
    logic bus16;
    logic [15:0] addr_low;
    logic [15:0] addr_mid;
    logic [15:0] addr_high;
    logic [15:0] clk_ctrl;
    logic [1:0] div_cnt;
    logic bus_tick;
    logic nvm_rd;
    logic [7:0] nvm_addr;
    logic load_busy;
    hcsmr_rsp_t rsp;
  } hcsmr_state_t;

endpackage : hcsmr_pkg

/* File: verilog/hcsmr_regs.sv */
// What this block does
// - Illegal byte enables set bus error flag
// - Flag cleared only by writing one
// - Capture byte enables into bits 14-11
// - Bit 10 latches endian strap at reset
// - Bit 9 latches memory-enable strap at reset
// - Bit 7 reports eight-bit bus width
// - Bit 6 reports sixteen-bit bus width
// - Bit 5 reports thirty-two-bit variant
// - Bit 3 reports large package; read-only
// - Load station address from word 1 on
// - Words 1,2,3 go low, middle, high
// - Host access never changes memory contents
// - Three sixteen-bit read/write address words
// - Internal bus clock defaults to 125 MHz
// - Bits 1-0 pick divide by 1,2,3
// - Address load only when strap high
`timescale 1ns/1ps

module hcsmr_regs #(
  parameter logic IS_BUS32 = 1'b0,
  parameter logic IS_LARGE_PKG = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire hcsmr_pkg::hcsmr_req_t REQ_I,
  output logic [15:0] RDATA_O,
  output logic RVALID_O,
  input wire logic NVM_SERIAL_CLOCK_PIN_I,
  input wire logic NVM_ENABLE_STRAP_I,
  input wire logic NVM_SERIAL_DATA_IN_PIN_I,
  output logic NVM_RD_O,
  output logic [7:0] NVM_ADDR_O,
  input wire logic NVM_VALID_I,
  input wire logic [15:0] NVM_DATA_I,
  input wire logic NVM_BUS8_I,
  input wire logic NVM_BUS16_I,
  output logic LOAD_BUSY_O,
  output logic BUS_TICK_O,
  output logic [1:0] BUS_DIV_O,
  output logic DRIVE_STRONG_O
);

  hcsmr_pkg::hcsmr_state_t s_reg;
  hcsmr_pkg::hcsmr_state_t s_next;

  ////////////////////////////////////////////////////////////////////////////

  // Legal lanes: single byte, aligned half words, or full word
  function automatic logic be_legal(input logic [3:0] be_n);
    logic [3:0] be;
    be = ~be_n;
    unique case (be)
      4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_legal = 1'b1;
      default: be_legal = 1'b0;
    endcase
  endfunction : be_legal

  function automatic logic [15:0] div_tick_limit(input logic [1:0] sel);
    div_tick_limit = {14'h0000, sel};
  endfunction : div_tick_limit

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [15:0] rd;
    logic hit_write;
    rd = 16'h0000;
    s_next = s_reg;
    hit_write = REQ_I.strb && REQ_I.wr;

    // Strap pins are async to the clock
    s_next.pin_sync1 = {NVM_SERIAL_CLOCK_PIN_I, NVM_ENABLE_STRAP_I, NVM_SERIAL_DATA_IN_PIN_I};
    s_next.pin_sync2 = s_reg.pin_sync1;

    // Straps caught once; wait two edges so the synchroniser holds real pin levels
    if (!s_reg.strap_taken) begin
      if (s_reg.sync_cnt == 2'h2) begin
        s_next.strap_taken = 1'b1;
        s_next.endian = s_reg.pin_sync2[2];
        s_next.nvm_en = s_reg.pin_sync2[1];
      end else begin
        s_next.sync_cnt = s_reg.sync_cnt + 2'h1;
      end
    end

    // Internal bus clock enable; divider field steers the rate
    s_next.bus_tick = 1'b0;
    if ({14'h0000, s_reg.div_cnt} >= div_tick_limit(s_reg.clk_ctrl[1:0])) begin
      s_next.div_cnt = 2'h0;
      s_next.bus_tick = 1'b1;
    end else begin
      s_next.div_cnt = s_reg.div_cnt + 2'h1;
    end

    // Address load sequence; memory is only ever read
    s_next.nvm_rd = 1'b0;
    unique case (s_reg.ld)
      hcsmr_pkg::LD_IDLE: begin
        if (s_reg.strap_taken) begin
          if (s_reg.nvm_en) begin
            s_next.ld = hcsmr_pkg::LD_REQ;
            s_next.word_idx = 2'h0;
            s_next.load_busy = 1'b1;
          end else begin
            // Width straps sampled from the data pin without memory
            s_next.bus8 = s_reg.pin_sync2[0];
            s_next.bus16 = ~s_reg.pin_sync2[0];
            s_next.ld = hcsmr_pkg::LD_DONE;
          end
        end
      end
      hcsmr_pkg::LD_REQ: begin
        s_next.nvm_rd = 1'b1;
        s_next.nvm_addr = hcsmr_pkg::NVM_WORD_LOW + {6'h00, s_reg.word_idx};
        s_next.ld = hcsmr_pkg::LD_WAIT;
      end
      hcsmr_pkg::LD_WAIT: begin
        if (NVM_VALID_I) begin
          unique case (s_reg.word_idx)
            2'h0: s_next.addr_low = NVM_DATA_I;
            2'h1: s_next.addr_mid = NVM_DATA_I;
            default: s_next.addr_high = NVM_DATA_I;
          endcase
          if (s_reg.word_idx == 2'h2) begin
            s_next.bus8 = NVM_BUS8_I;
            s_next.bus16 = NVM_BUS16_I;
            s_next.load_busy = 1'b0;
            s_next.ld = hcsmr_pkg::LD_DONE;
          end else begin
            s_next.word_idx = s_reg.word_idx + 2'h1;
            s_next.ld = hcsmr_pkg::LD_REQ;
          end
        end
      end
      hcsmr_pkg::LD_DONE: begin
        s_next.ld = hcsmr_pkg::LD_DONE;
      end
    endcase

    // Bad lane detection; capture only on a new event keeps first value
    if (REQ_I.strb && !be_legal(REQ_I.be_n)) begin
      s_next.bad_flag = 1'b1;
      if (!s_reg.bad_flag) begin
        s_next.bad_val = ~REQ_I.be_n;
      end
    end else if (hit_write && REQ_I.addr == hcsmr_pkg::OFF_BUS_ERR
                 && REQ_I.wdata[hcsmr_pkg::BAD_FLAG_BIT]) begin
      s_next.bad_flag = 1'b0;
    end

    // Register writes only touch local flops, never the memory
    if (hit_write && be_legal(REQ_I.be_n)) begin
      unique case (REQ_I.addr)
        hcsmr_pkg::OFF_ADDR_LOW: s_next.addr_low = REQ_I.wdata;
        hcsmr_pkg::OFF_ADDR_MID: s_next.addr_mid = REQ_I.wdata;
        hcsmr_pkg::OFF_ADDR_HIGH: s_next.addr_high = REQ_I.wdata;
        hcsmr_pkg::OFF_CLK_CTRL: begin
          // Reserved bits ignored on write
          s_next.clk_ctrl = REQ_I.wdata & hcsmr_pkg::CLK_CTRL_WMASK;
        end
        default: begin
        end
      endcase
    end

    // Read mux; unmapped offsets read zero
    unique case (REQ_I.addr)
      hcsmr_pkg::OFF_BUS_ERR: begin
        rd[hcsmr_pkg::BAD_FLAG_BIT] = s_reg.bad_flag;
        rd[hcsmr_pkg::BAD_VAL_LSB +: 4] = s_reg.bad_val;
      end
      hcsmr_pkg::OFF_STRAP_CFG: begin
        rd[hcsmr_pkg::CFG_ENDIAN_BIT] = s_reg.endian;
        rd[hcsmr_pkg::CFG_NVM_BIT] = s_reg.nvm_en;
        rd[hcsmr_pkg::CFG_BUS8_BIT] = s_reg.bus8;
        rd[hcsmr_pkg::CFG_BUS16_BIT] = s_reg.bus16;
        rd[hcsmr_pkg::CFG_BUS32_BIT] = IS_BUS32;
        rd[hcsmr_pkg::CFG_PKG_BIT] = IS_LARGE_PKG;
      end
      hcsmr_pkg::OFF_ADDR_LOW: rd = s_reg.addr_low;
      hcsmr_pkg::OFF_ADDR_MID: rd = s_reg.addr_mid;
      hcsmr_pkg::OFF_ADDR_HIGH: rd = s_reg.addr_high;
      hcsmr_pkg::OFF_CLK_CTRL: rd = s_reg.clk_ctrl;
      default: rd = 16'h0000;
    endcase

    s_next.rsp.rvalid = REQ_I.strb && !REQ_I.wr;
    s_next.rsp.rdata = (REQ_I.strb && !REQ_I.wr) ? rd : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_reg <= '0;
      s_reg.ld <= hcsmr_pkg::LD_IDLE;
      // Divide by one selects the 125 MHz default
      s_reg.clk_ctrl <= hcsmr_pkg::CLK_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA_O = s_reg.rsp.rdata;
  assign RVALID_O = s_reg.rsp.rvalid;
  assign NVM_RD_O = s_reg.nvm_rd;
  assign NVM_ADDR_O = s_reg.nvm_addr;
  assign LOAD_BUSY_O = s_reg.load_busy;
  assign BUS_TICK_O = s_reg.bus_tick;
  assign BUS_DIV_O = s_reg.clk_ctrl[1:0];
  assign DRIVE_STRONG_O = s_reg.clk_ctrl[hcsmr_pkg::CLK_DRIVE_BIT];

endmodule : hcsmr_regs

/* File: dv/hcsmr_regs_monitor.sv */
`timescale 1ns/1ps
module hcsmr_regs_monitor (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire hcsmr_pkg::hcsmr_req_t REQ_I,
  input wire logic [15:0] RDATA_O,
  input wire logic RVALID_O,
  input wire logic NVM_RD_O,
  input wire logic [7:0] NVM_ADDR_O,
  input wire logic NVM_VALID_I,
  input wire logic LOAD_BUSY_O,
  input wire logic BUS_TICK_O,
  input wire logic [1:0] BUS_DIV_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  function automatic logic lgl(input logic [3:0] b);
    return b inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  endfunction : lgl
  wire logic rd = REQ_I.strb && !REQ_I.wr;
  wire logic wr_ok = REQ_I.strb && REQ_I.wr && lgl(~REQ_I.be_n);
  wire logic bad = REQ_I.strb && !lgl(~REQ_I.be_n);
  sequence s_rd;
    rd && REQ_I.addr == 8'h06 && lgl(~REQ_I.be_n);
  endsequence
  sequence s_clr;
    wr_ok && REQ_I.addr == 8'h06 && REQ_I.wdata[15];
  endsequence
  ////////////////////////////////////////
  AST_RD_ANS: assert property (rd |=> RVALID_O) else $error("read not answered");
  AST_ERR_SET: assert property (bad ##2 s_rd |=> RDATA_O[15])
    else $error("error flag not set");
  AST_ERR_CLR: assert property (s_clr ##2 s_rd |=> !RDATA_O[15])
    else $error("error flag not cleared");
  AST_RSV: assert property (rd && !REQ_I.addr[0]
    && !(REQ_I.addr inside {8'h06, 8'h08, 8'h10, 8'h12, 8'h14, 8'h20})
    |=> RDATA_O == 16'h0000) else $error("reserved offset not zero");
  AST_DIV: assert property (wr_ok && REQ_I.addr == 8'h20
    |=> BUS_DIV_O == $past(REQ_I.wdata[1:0])) else $error("divider not stored");
  AST_KEEP: assert property (bad |=> $stable(BUS_DIV_O)) else $error("bad write stored");
  // Three quiet cycles so the divider phase has settled
  AST_TICK1: assert property (RSTN_I && $past(RSTN_I, 3)
    && (BUS_DIV_O | $past(BUS_DIV_O) | $past(BUS_DIV_O, 2)) == 2'h0
    |-> BUS_TICK_O) else $error("divide by one not ticking");
  AST_ORDER: assert property (NVM_RD_O && NVM_ADDR_O != 8'h01
    |-> NVM_ADDR_O == $past(NVM_ADDR_O) + 8'h01) else $error("word order broken");
  AST_LOAD_END: assert property (LOAD_BUSY_O && NVM_VALID_I && NVM_ADDR_O == 8'h03
    |=> !LOAD_BUSY_O) else $error("load did not end");
endmodule : hcsmr_regs_monitor
bind hcsmr_regs hcsmr_regs_monitor u_mon (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .REQ_I(REQ_I),
  .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .NVM_RD_O(NVM_RD_O), .NVM_ADDR_O(NVM_ADDR_O),
  .NVM_VALID_I(NVM_VALID_I), .LOAD_BUSY_O(LOAD_BUSY_O), .BUS_TICK_O(BUS_TICK_O),
  .BUS_DIV_O(BUS_DIV_O));

/* File: dv/hcsmr_nvm_model.sv */
`timescale 1ns/1ps
module hcsmr_nvm_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  output logic valid_o,
  output logic [15:0] data_o
);
  logic [2:0] wait_cnt;
  logic [1:0] word;
  // Read-only store, no write path at all
  function automatic logic [15:0] mem(input logic [1:0] w);
    case (w)
      2'h1: return 16'h89ab;
      2'h2: return 16'h4567;
      default: return 16'h0123;
    endcase
  endfunction : mem
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_cnt <= 3'h0;
      valid_o <= 1'b0;
      data_o <= 16'h0000;
      word <= 2'h0;
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o; // Idle data toggles so stale values never match
      if (rd_i) begin
        word <= addr_i[1:0];
        wait_cnt <= (addr_i == 8'h02) ? 3'h6 : 3'h1; // Middle word answers slowly
      end else if (wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
        if (wait_cnt == 3'h1) begin
          valid_o <= 1'b1;
          data_o <= mem(word);
        end
      end
    end
  end
endmodule : hcsmr_nvm_model

/* File: dv/tb_hcsmr_regs.sv */
`timescale 1ns/1ps
module tb_hcsmr_regs;
  logic CLK_I = 1'b0;
  logic RSTN_I;
  hcsmr_pkg::hcsmr_req_t REQ_I;
  logic [15:0] RDATA_O, nvm_data;
  logic RVALID_O, pin_e, strap, pin_d, nvm_rd, nvm_valid, busy, tick, drive;
  logic [7:0] nvm_addr;
  logic [1:0] div;
  int err_count = 0, comparisons = 0, reads = 0;
  always #5 CLK_I = ~CLK_I;
  always @(posedge CLK_I) reads += (nvm_rd === 1'b1);
  hcsmr_regs uut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .REQ_I(REQ_I), .RDATA_O(RDATA_O),
    .RVALID_O(RVALID_O), .NVM_SERIAL_CLOCK_PIN_I(pin_e), .NVM_ENABLE_STRAP_I(strap),
    .NVM_SERIAL_DATA_IN_PIN_I(pin_d), .NVM_RD_O(nvm_rd), .NVM_ADDR_O(nvm_addr),
    .NVM_VALID_I(nvm_valid), .NVM_DATA_I(nvm_data), .NVM_BUS8_I(1'b0), .NVM_BUS16_I(1'b1),
    .LOAD_BUSY_O(busy), .BUS_TICK_O(tick), .BUS_DIV_O(div), .DRIVE_STRONG_O(drive));
  hcsmr_nvm_model u_nvm (.clk_i(CLK_I), .rstn_i(RSTN_I), .rd_i(nvm_rd), .addr_i(nvm_addr),
    .valid_o(nvm_valid), .data_o(nvm_data));
  ////////////////////////////////////////
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] be);
    @(posedge CLK_I);
    REQ_I <= '{1'b1, 1'b1, a, be, d};
    @(posedge CLK_I);
    REQ_I.strb <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge CLK_I);
    REQ_I <= '{1'b1, 1'b0, a, 4'h0, 16'h0000};
    @(posedge CLK_I);
    REQ_I.strb <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, {15'h0000, RVALID_O});
    chk("rdata", e, RDATA_O & m);
  endtask : rd
  task do_reset(input logic s, input logic e, input logic d);
    @(posedge CLK_I);
    RSTN_I <= 1'b0;
    strap <= s;
    pin_e <= e;
    pin_d <= d;
    repeat (8) @(posedge CLK_I);
    reads = 0;
    RSTN_I <= 1'b1;
    repeat (5) @(posedge CLK_I);
    #1;
    for (int i = 0; i < 60 && busy !== 1'b0; i++) begin
      @(posedge CLK_I);
      #1;
    end
  endtask : do_reset
  ////////////////////////////////////////
  task t_load;
    rd(8'h10, 16'hffff, 16'h89ab);
    rd(8'h12, 16'hffff, 16'h4567);
    rd(8'h14, 16'hffff, 16'h0123);
    rd(8'h08, 16'hffff, 16'h0648);
    rd(8'h20, 16'hffff, 16'h0000);
  endtask : t_load
  task t_regs;
    wr(8'h10, 16'ha55a, 4'h0);
    rd(8'h10, 16'hffff, 16'ha55a);
    wr(8'h08, 16'hffff, 4'h0);
    rd(8'h08, 16'hffff, 16'h0648);
    rd(8'h0a, 16'hffff, 16'h0000);
    chk("nvm reads", 16'h0003, 16'(reads));
  endtask : t_regs
  task t_err;
    wr(8'h20, 16'h0001, 4'ha);
    #1;
    chk("div", 16'h0000, {14'h0000, div});
    rd(8'h06, 16'hffff, 16'ha800);
    wr(8'h06, 16'h0000, 4'h0);
    rd(8'h06, 16'h8000, 16'h8000);
    wr(8'h06, 16'h8000, 4'h0);
    rd(8'h06, 16'h8000, 16'h0000);
  endtask : t_err
  task t_div;
    int n;
    for (int d = 0; d < 3; d++) begin
      wr(8'h20, 16'h0040 | 16'(d), 4'h0);
      rd(8'h20, 16'hffff, 16'h0040 | 16'(d));
      n = 0;
      repeat (12) begin
        @(posedge CLK_I);
        #1;
        n += tick;
      end
      chk("ticks", 16'(12 / (d + 1)), 16'(n));
      chk("drive", 16'h0001, {15'h0000, drive});
    end
  endtask : t_div
  task t_nostrap;
    do_reset(1'b0, 1'b0, 1'b1);
    chk("nvm reads", 16'h0000, 16'(reads));
    rd(8'h10, 16'hffff, 16'h0000);
    rd(8'h08, 16'hffff, 16'h0088);
  endtask : t_nostrap
  ////////////////////////////////////////
  task wrap_up;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  initial begin
    REQ_I = '0;
    RSTN_I = 1'b0;
    {strap, pin_e, pin_d} = 3'h0;
    do_reset(1'b1, 1'b1, 1'b0);
    t_load;
    t_regs;
    t_err;
    t_div;
    t_nostrap;
    wrap_up;
  end
  // Whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge CLK_I);
    err_count++;
    wrap_up;
  end
endmodule : tb_hcsmr_regs
